/* File: inc/pxr_defines.vh */
/*
 * Constants for the port pin crossbar: register addresses on the
 * special-function bus, field positions, reset values, and the
 * fixed priority index of every routable peripheral signal except the four PCA outputs after PXR_S_CEX0, which are offsets from it.
 * Assumes it is included by bare name from the hdl files.
 */
`ifndef PXR_DEFINES_VH
`define PXR_DEFINES_VH

// special-function register addresses
`define PXR_ADDR_CFG0        8'he1
`define PXR_ADDR_CFG1        8'he2
`define PXR_ADDR_CFG2        8'he3

// reset values
`define PXR_RST_CFG0         8'h00
`define PXR_RST_CFG1         8'h00
`define PXR_RST_CFG2         8'h00

// pin_router_cfg0 fields
`define PXR_C0_SMB_EN        0
`define PXR_C0_SPI_EN        1
`define PXR_C0_UART_EN       2
`define PXR_C0_PCA_LO        3
`define PXR_C0_PCA_HI        5
`define PXR_C0_ECI_EN        6
`define PXR_C0_CMP0_EN       7
`define PXR_PCA_MAX          3'h5

// pin_router_cfg1 fields
`define PXR_C1_CMP1_EN       0
`define PXR_C1_T0_EN         1
`define PXR_C1_IRQ0_EN       2
`define PXR_C1_T1_EN         3
`define PXR_C1_IRQ1_EN       4
`define PXR_C1_T2_EN         5
`define PXR_C1_TIMER2_EXT_TRIGGER_EN       6
`define PXR_C1_CLK_EN        7

// pin_router_cfg2 fields
`define PXR_C2_CONV_EN       0
`define PXR_C2_ROUTER_EN     6
`define PXR_C2_PULLOFF       7
`define PXR_C2_WMASK         8'hc1

// pins and signals
`define PXR_NPIN             24
`define PXR_NSIG             24
`define PXR_SLOT_W           5

// signal priority order, highest first
`define PXR_S_SDA            0
`define PXR_S_SCL            1
`define PXR_S_SCK            2
`define PXR_S_MISO           3
`define PXR_S_MOSI           4
`define PXR_S_NSS            5
`define PXR_S_TX             6
`define PXR_S_RX             7
`define PXR_S_CEX0           8
`define PXR_S_ECI            13
`define PXR_S_CMP0           14
`define PXR_S_CMP1           15
`define PXR_S_T0             16
`define PXR_S_IRQ0           17
`define PXR_S_T1             18
`define PXR_S_IRQ1           19
`define PXR_S_T2             20
`define PXR_S_TIMER2_EXT_TRIGGER           21
`define PXR_S_CONV           22
`define PXR_S_CLK            23

`endif

/* File: hdl/pxr_regs.v */
/*
 * Crossbar configuration registers on the special-function bus.
 * Assumes single-cycle write and read strobes synchronous to sys_clk;
 * read data is registered and appears the cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pxr_defines.vh"

module pxr_regs (
    input  wire       sys_clk,
    input  wire       srst,
    input  wire [7:0] sfr_addr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_we,
    input  wire       sfr_re,
    output reg  [7:0] sfr_rdata,
    output reg  [7:0] cfg0_r,
    output reg  [7:0] cfg1_r,
    output reg  [7:0] cfg2_r
);

    reg [7:0] rdata_nxt;

    always @* begin
        case (sfr_addr)
            `PXR_ADDR_CFG0: rdata_nxt = cfg0_r;
            `PXR_ADDR_CFG1: rdata_nxt = cfg1_r;
            `PXR_ADDR_CFG2: rdata_nxt = cfg2_r; // RULE_11
            default:        rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            cfg0_r    <= `PXR_RST_CFG0;
            cfg1_r    <= `PXR_RST_CFG1;
            cfg2_r    <= `PXR_RST_CFG2;
            sfr_rdata <= 8'h00;
        end else begin
            if (sfr_we && sfr_addr == `PXR_ADDR_CFG0) begin
                cfg0_r <= sfr_wdata; // RULE_16
            end
            if (sfr_we && sfr_addr == `PXR_ADDR_CFG1) begin
                cfg1_r <= sfr_wdata;
            end
            if (sfr_we && sfr_addr == `PXR_ADDR_CFG2) begin
                // unused bits never store, so they read back zero
                cfg2_r <= sfr_wdata & `PXR_C2_WMASK; // RULE_11
            end
            if (sfr_re) begin
                sfr_rdata <= rdata_nxt;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

endmodule
`default_nettype wire

/* File: hdl/pxr_alloc.v */
/*
 * Priority slot allocator: each enabled signal gets the pin index
 * equal to the number of enabled signals ahead of it.
 * Assumes the enable vector is ordered highest priority first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pxr_defines.vh"

module pxr_alloc (
    input  wire [`PXR_NSIG-1:0]             sig_en,
    output wire [`PXR_NSIG*`PXR_SLOT_W-1:0] sig_slot
);

    genvar g;
    generate
        for (g = 0; g < `PXR_NSIG; g = g + 1) begin : g_slot
            reg [`PXR_SLOT_W-1:0] cnt;
            integer k;
            always @* begin
                cnt = {`PXR_SLOT_W{1'b0}};
                // disabled signals add nothing, so no gap is left
                for (k = 0; k < g; k = k + 1) begin
                    cnt = cnt + {{(`PXR_SLOT_W-1){1'b0}}, sig_en[k]}; // RULE_15
                end
            end
            assign sig_slot[g*`PXR_SLOT_W +: `PXR_SLOT_W] = cnt; // RULE_13
        end
    endgenerate

endmodule
`default_nettype wire

/* File: hdl/pxr_top.v */
/*
 * Port pin crossbar: routes enabled peripheral signals onto the 24
 * port pins (port 0 pin 0 up to port 2 pin 7) in fixed priority
 * order, falls back to the port data latch on unassigned pins, and
 * controls the weak pull-ups.
 * Assumes all inputs are synchronous to sys_clk, and that each
 * peripheral presents its output value and output enable per signal.
 */
// Function
// RULE_01: the core clock reaches a pin only while core_clock_out_en is set.
// RULE_02: timer2_ext_trigger_pin_en routes the timer 2 trigger input.
// RULE_03: timer2_count_pin_en routes the timer 2 count input.
// RULE_04: ext_irq1_pin_en routes the external interrupt 1 line.
// RULE_05: timer1_count_pin_en routes the timer 1 count input.
// RULE_06: ext_irq0_pin_en routes the external interrupt 0 line.
// RULE_07: timer0_count_pin_en routes the timer 0 count input.
// RULE_08: cmp1_out_pin_en drives comparator 1 output onto a pin.
// RULE_09: pull-ups are on for non push-pull pins unless pullup_global_off.
// RULE_10: with pin_router_en clear no peripheral signal reaches a pin.
// RULE_11: unused bits of pin_router_cfg2 read zero and ignore writes.
// RULE_12: conv_start_pin_en routes the converter start input.
// RULE_13: enabled signals fill pins in order from port 0 pin 0 upward.
// RULE_14: an unassigned pin follows its bit of the port data latch.
// RULE_15: one fixed signal order is used and disabled signals leave no gap.
// RULE_16: pin_router_cfg0 holds the remaining peripheral route enables.
`timescale 1ns/1ps
`default_nettype none
`include "pxr_defines.vh"

module pxr_top (
    input  wire                 sys_clk,
    input  wire                 srst,
    input  wire [7:0]           sfr_addr,
    input  wire [7:0]           sfr_wdata,
    input  wire                 sfr_we,
    input  wire                 sfr_re,
    output wire [7:0]           sfr_rdata,
    input  wire [`PXR_NPIN-1:0] port_latch,
    input  wire [`PXR_NPIN-1:0] port_pushpull,
    input  wire [`PXR_NPIN-1:0] pin_in,
    output reg  [`PXR_NPIN-1:0] pin_out_r,
    output reg  [`PXR_NPIN-1:0] pin_oe_r,
    output reg  [`PXR_NPIN-1:0] pin_pullup_r,
    input  wire [`PXR_NSIG-1:0] periph_out,
    input  wire [`PXR_NSIG-1:0] periph_oe,
    output reg  [`PXR_NSIG-1:0] periph_in_r,
    output reg  [`PXR_NSIG-1:0] sig_routed_r
);

    wire [7:0]                         cfg0;
    wire [7:0]                         cfg1;
    wire [7:0]                         cfg2;
    wire [`PXR_NSIG*`PXR_SLOT_W-1:0]   sig_slot;
    reg  [`PXR_NSIG-1:0]               sig_en;
    wire [2:0]                         pca_cnt;
    wire [`PXR_NPIN-1:0]               pin_out_nxt;
    wire [`PXR_NPIN-1:0]               pin_oe_nxt;
    wire [`PXR_NPIN-1:0]               pin_pullup_nxt;
    wire [`PXR_NSIG-1:0]               periph_in_nxt;

    pxr_regs u_regs (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .sfr_addr  (sfr_addr),
        .sfr_wdata (sfr_wdata),
        .sfr_we    (sfr_we),
        .sfr_re    (sfr_re),
        .sfr_rdata (sfr_rdata),
        .cfg0_r    (cfg0),
        .cfg1_r    (cfg1),
        .cfg2_r    (cfg2)
    );

    assign pca_cnt = cfg0[`PXR_C0_PCA_HI:`PXR_C0_PCA_LO];

    // enable vector in priority order
    always @* begin
        sig_en = {`PXR_NSIG{1'b0}};
        sig_en[`PXR_S_SDA]  = cfg0[`PXR_C0_SMB_EN]; // RULE_16
        sig_en[`PXR_S_SCL]  = cfg0[`PXR_C0_SMB_EN];
        sig_en[`PXR_S_SCK]  = cfg0[`PXR_C0_SPI_EN];
        sig_en[`PXR_S_MISO] = cfg0[`PXR_C0_SPI_EN];
        sig_en[`PXR_S_MOSI] = cfg0[`PXR_C0_SPI_EN];
        sig_en[`PXR_S_NSS]  = cfg0[`PXR_C0_SPI_EN];
        sig_en[`PXR_S_TX]   = cfg0[`PXR_C0_UART_EN];
        sig_en[`PXR_S_RX]   = cfg0[`PXR_C0_UART_EN];
        // reserved counts above five route no module output
        if (pca_cnt <= `PXR_PCA_MAX) begin
            sig_en[`PXR_S_CEX0 +: 5] = ~(5'h1f << pca_cnt);
        end
        sig_en[`PXR_S_ECI]  = cfg0[`PXR_C0_ECI_EN];
        sig_en[`PXR_S_CMP0] = cfg0[`PXR_C0_CMP0_EN];
        sig_en[`PXR_S_CMP1] = cfg1[`PXR_C1_CMP1_EN]; // RULE_08
        sig_en[`PXR_S_T0]   = cfg1[`PXR_C1_T0_EN];   // RULE_07
        sig_en[`PXR_S_IRQ0] = cfg1[`PXR_C1_IRQ0_EN]; // RULE_06
        sig_en[`PXR_S_T1]   = cfg1[`PXR_C1_T1_EN];   // RULE_05
        sig_en[`PXR_S_IRQ1] = cfg1[`PXR_C1_IRQ1_EN]; // RULE_04
        sig_en[`PXR_S_T2]   = cfg1[`PXR_C1_T2_EN];   // RULE_03
        sig_en[`PXR_S_TIMER2_EXT_TRIGGER] = cfg1[`PXR_C1_TIMER2_EXT_TRIGGER_EN]; // RULE_02
        sig_en[`PXR_S_CONV] = cfg2[`PXR_C2_CONV_EN]; // RULE_12
        sig_en[`PXR_S_CLK]  = cfg1[`PXR_C1_CLK_EN];  // RULE_01
        if (!cfg2[`PXR_C2_ROUTER_EN]) begin
            sig_en = {`PXR_NSIG{1'b0}}; // RULE_10
        end
    end

    pxr_alloc u_alloc (
        .sig_en   (sig_en),
        .sig_slot (sig_slot)
    );

    genvar p;
    generate
        for (p = 0; p < `PXR_NPIN; p = p + 1) begin : g_pin
            reg     hit;
            reg     o_val;
            reg     o_en;
            integer s;
            always @* begin
                hit   = 1'b0;
                o_val = port_latch[p];
                // open-drain port pins drive only a low
                o_en  = port_pushpull[p] | ~port_latch[p];
                for (s = 0; s < `PXR_NSIG; s = s + 1) begin
                    if (sig_en[s] &&
                        sig_slot[s*`PXR_SLOT_W +: `PXR_SLOT_W] == p) begin
                        hit   = 1'b1; // RULE_13
                        o_val = periph_out[s];
                        o_en  = periph_oe[s];
                    end
                end
                if (!hit) begin
                    o_val = port_latch[p]; // RULE_14
                end
            end
            assign pin_out_nxt[p]    = o_val;
            assign pin_oe_nxt[p]     = o_en;
            assign pin_pullup_nxt[p] = ~cfg2[`PXR_C2_PULLOFF] &
                                       ~port_pushpull[p]; // RULE_09
        end
    endgenerate

    genvar q;
    generate
        for (q = 0; q < `PXR_NSIG; q = q + 1) begin : g_sig
            wire [`PXR_SLOT_W-1:0] slot;
            assign slot = sig_slot[q*`PXR_SLOT_W +: `PXR_SLOT_W];
            // unrouted inputs idle high so active-low lines stay quiet
            assign periph_in_nxt[q] = sig_en[q] ? pin_in[slot] : 1'b1;
        end
    endgenerate

    // outputs are registered; pin updates lag config by one cycle
    always @(posedge sys_clk) begin
        if (srst) begin
            pin_out_r    <= {`PXR_NPIN{1'b0}};
            pin_oe_r     <= {`PXR_NPIN{1'b0}};
            pin_pullup_r <= {`PXR_NPIN{1'b0}};
            periph_in_r  <= {`PXR_NSIG{1'b1}};
            sig_routed_r <= {`PXR_NSIG{1'b0}};
        end else begin
            pin_out_r    <= pin_out_nxt;
            pin_oe_r     <= pin_oe_nxt;
            pin_pullup_r <= pin_pullup_nxt;
            periph_in_r  <= periph_in_nxt;
            sig_routed_r <= sig_en;
        end
    end

endmodule
`default_nettype wire

/* File: tb/pxr_periph_model.sv */
/*
 * Far side of the crossbar: peripherals and external pin drivers.
 * Assumes refresh is raised by the bench; new values land on a falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pxr_periph_model (
    input  wire logic        sys_clk,
    input  wire logic        refresh,
    input  wire logic [23:0] pin_out_r,
    input  wire logic [23:0] pin_oe_r,
    output logic      [23:0] periph_out,
    output logic      [23:0] periph_oe,
    output wire logic [23:0] pin_in
);
    logic [23:0] ext_lvl;
    initial begin
        periph_out = 24'h000000;
        periph_oe = 24'h000000;
        ext_lvl = 24'h000000;
    end
    always @(negedge sys_clk) begin
        if (refresh) begin
            periph_out <= $urandom;
            periph_oe <= $urandom;
            ext_lvl <= $urandom;
        end
    end
    // a driven pin shows the device level, an undriven one the outside level
    assign pin_in = (pin_oe_r & pin_out_r) | (~pin_oe_r & ext_lvl);
endmodule
`default_nettype wire

/* File: tb/pxr_monitor.sv */
/*
 * Assertions on the crossbar top ports.
 * Assumes the bind below; register copies are rebuilt from bus writes.
 */
`timescale 1ns/1ps
`default_nettype none
module pxr_monitor (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_we,
    input wire logic        sfr_re,
    input wire logic [7:0]  sfr_rdata,
    input wire logic [23:0] port_latch,
    input wire logic [23:0] port_pushpull,
    input wire logic [23:0] periph_out,
    input wire logic [23:0] pin_out_r,
    input wire logic [23:0] pin_oe_r,
    input wire logic [23:0] pin_pullup_r,
    input wire logic [23:0] periph_in_r,
    input wire logic [23:0] sig_routed_r
);
    logic [7:0] c0_r, c1_r, c2_r;
    wire  [7:0] rd_exp = sfr_addr == 8'he1 ? c0_r :
                         sfr_addr == 8'he2 ? c1_r :
                         sfr_addr == 8'he3 ? c2_r : 8'h00;
    always @(posedge sys_clk) begin
        if (srst) begin
            c0_r <= 8'h00;
            c1_r <= 8'h00;
            c2_r <= 8'h00;
        end else if (sfr_we) begin
            if (sfr_addr == 8'he1) c0_r <= sfr_wdata;
            if (sfr_addr == 8'he2) c1_r <= sfr_wdata;
            if (sfr_addr == 8'he3) c2_r <= sfr_wdata & 8'hc1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    a_read_back: assert property (sfr_re |=>
        sfr_rdata == $past(rd_exp))
        else $error("read data differs from written configuration");
    a_read_idle: assert property (!sfr_re |=> sfr_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_routed_map: assert property (!$past(srst) |->
        sig_routed_r[23:15] ==
        ($past({c1_r[7], c2_r[0], c1_r[6:0]}) & {9{$past(c2_r[6])}}))
        else $error("routed flags do not follow enable bits");
    a_clock_gate: assert property (!$past(c1_r[7]) |->
        !sig_routed_r[23])
        else $error("core clock routed while disabled");
    a_router_off: assert property (!$past(c2_r[6]) |->
        sig_routed_r == 24'h0)
        else $error("signal routed with crossbar off");
    a_pullup_ctl: assert property (!$past(srst) |-> pin_pullup_r ==
        (~$past(port_pushpull) & {24{!$past(c2_r[7])}}))
        else $error("weak pull-up state wrong");
    a_idle_pins: assert property (!$past(srst) &&
        sig_routed_r == 24'h0 |->
        pin_out_r == $past(port_latch) && periph_in_r == 24'hffffff &&
        pin_oe_r == $past(port_pushpull | ~port_latch))
        else $error("unrouted pins do not follow port latch");
    a_first_slot: assert property (sig_routed_r[0] |->
        pin_out_r[0] == $past(periph_out[0]))
        else $error("first priority signal not on first pin");
    a_last_pin: assert property (!$past(srst) &&
        $countones(sig_routed_r) < 24 |->
        pin_out_r[23] == $past(port_latch[23]))
        else $error("last pin taken without full assignment");
endmodule
bind pxr_top pxr_monitor i_mon (.sys_clk, .srst, .sfr_addr, .sfr_wdata,
    .sfr_we, .sfr_re, .sfr_rdata, .port_latch, .port_pushpull, .periph_out,
    .pin_out_r, .pin_oe_r, .pin_pullup_r, .periph_in_r, .sig_routed_r);
`default_nettype wire

/* File: tb/tb.sv */
/*
 * Self-checking bench for the port pin crossbar.
 * Assumes the design header is on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk = 0, srst = 1, sfr_we = 0, sfr_re = 0, refresh = 0;
    logic [7:0]  sfr_addr = 0, sfr_wdata = 0;
    logic [23:0] port_latch = 0, port_pushpull = 0;
    wire  [7:0]  sfr_rdata;
    wire  [23:0] pin_in, pin_out_r, pin_oe_r, pin_pullup_r;
    wire  [23:0] periph_out, periph_oe, periph_in_r, sig_routed_r;
    int          error_cnt = 0, checks_done = 0, it;
    pxr_top i_dut (.sys_clk, .srst, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re,
        .sfr_rdata, .port_latch, .port_pushpull, .pin_in, .pin_out_r,
        .pin_oe_r, .pin_pullup_r, .periph_out, .periph_oe, .periph_in_r,
        .sig_routed_r);
    pxr_periph_model i_peri (.sys_clk, .refresh, .pin_out_r, .pin_oe_r,
        .periph_out, .periph_oe, .pin_in);
    initial forever #25 sys_clk = ~sys_clk;
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [23:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(negedge sys_clk);
        sfr_we = 1; sfr_addr = a; sfr_wdata = d;
        @(negedge sys_clk);
        sfr_we = 0;
    endtask
    task rd(input logic [7:0] a, exp);
        @(negedge sys_clk);
        sfr_re = 1; sfr_addr = a;
        @(negedge sys_clk);
        sfr_re = 0;
        chk({16'h0, sfr_rdata}, {16'h0, exp}, "read");
    endtask
    // reserved module-output codes route nothing
    function automatic logic [23:0] en_vec(input logic [7:0] x0, x1, x2);
        logic [23:0] e;
        e = {x1[7], x2[0], x1[6:0], x0[7:6], 5'h00, {2{x0[2]}},
             {4{x0[1]}}, {2{x0[0]}}};
        for (int i = 0; i < 5; i++) e[8+i] = x0[5:3] <= 3'h5 && i < x0[5:3];
        return e & {24{x2[6]}};
    endfunction
    task pins(input logic [7:0] x0, x1, x2);
        logic [23:0] e, o, oe, pi;
        int k;
        wr(8'he1, x0);
        wr(8'he2, x1);
        wr(8'he3, x2);
        refresh <= 1;
        port_latch <= $urandom;
        port_pushpull <= $urandom;
        @(negedge sys_clk);
        refresh <= 0;
        repeat (3) @(negedge sys_clk);
        e = en_vec(x0, x1, x2);
        o = port_latch;
        oe = port_pushpull | ~port_latch;
        pi = 24'hffffff;
        k = 0;
        for (int i = 0; i < 24; i++) if (e[i]) begin
            o[k] = periph_out[i];
            oe[k] = periph_oe[i];
            pi[i] = pin_in[k];
            k++;
        end
        chk(sig_routed_r, e, "routed");
        chk(pin_out_r, o, "pin value");
        chk(pin_oe_r, oe, "pin drive");
        chk(periph_in_r, pi, "peripheral input");
        chk(pin_pullup_r, ~port_pushpull & {24{~x2[7]}}, "pullup");
        rd(8'he2, x1);
        rd(8'he3, x2 & 8'hc1);
        $display("test %h %h %h done", x0, x1, x2);
    endtask
    initial begin
        it = $urandom(90);
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        srst = 0;
        rd(8'he3, 8'h00);
        pins(8'h11, 8'h00, 8'h40);
        chk(sig_routed_r, 24'h000303, "first example");
        pins(8'h80, 8'h04, 8'h41);
        chk(sig_routed_r, 24'h424000, "second example");
        pins(8'hff, 8'hff, 8'hbf);
        pins(8'hef, 8'hff, 8'hff);
        rd(8'he0, 8'h00);
        for (it = 0; it < 8; it++) pins(8'h00, 8'h01 << it, 8'h41);
        for (it = 0; it < 30; it++) pins($urandom, $urandom, $urandom);
        srst = 1;
        @(negedge sys_clk);
        srst = 0;
        rd(8'he2, 8'h00);
        chk(periph_in_r, 24'hffffff, "after reset");
        wrap_up;
    end
    initial begin
        #(50 * 6000);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up;
    end
endmodule
`default_nettype wire
